// [logic/sas_pkg.sv]
package sas_pkg;
   localparam int NCH = 12;
   localparam int RW = 12;
   localparam int CONV_TICKS = 12;
   localparam logic [7:0] A_MODE = 8'h00;
   localparam logic [7:0] A_CTRL = 8'h04;
   localparam logic [7:0] A_INTERVAL = 8'h08;
   localparam logic [7:0] A_IMODE = 8'h0C;
   localparam logic [7:0] A_LIMMODE = 8'h10;
   localparam logic [7:0] A_UPPER = 8'h14;
   localparam logic [7:0] A_LOWER = 8'h18;
   localparam logic [7:0] A_CHEN = 8'h1C;
   localparam logic [7:0] A_LSTAT = 8'h20;
   localparam logic [7:0] A_LCLR = 8'h24;
   localparam logic [7:0] A_LAST = 8'h34;
   localparam logic [7:0] A_RES0 = 8'h38;
   localparam logic [7:0] A_RES11 = 8'h64;
   localparam logic [7:0] A_ISTAT = 8'h68;
   localparam logic [7:0] A_ICLR = 8'h6C;
   localparam logic [7:0] A_IEN = 8'h70;
   localparam int CTRL_START = 0;
   localparam int CTRL_CONT = 1;
   localparam int CTRL_TRIG = 2;
   localparam int CTRL_HALT = 3;
   localparam int CTRL_STOP = 4;
   localparam int CTRL_RUN = 5;
   localparam int RES_LSB = 4;
   localparam int EV_CONV = 0;
   localparam int EV_DONE = 1;
   localparam int EV_LIMIT = 2;
   localparam int NEV = 3;
   localparam logic [15:0] MODE_RESET = 16'h0000;
   localparam logic [RW-1:0] UPPER_RESET = 12'hFFF;
   typedef struct packed {
      logic [3:0] sample_hold_time;
      logic [2:0] rsvd;
      logic discharge_enable;
      logic [3:0] init_phase_time;
      logic [1:0] rsvd2;
      logic [1:0] conv_clock_select;
   } sas_mode_t;
   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_INIT = 3'b001,
      S_SAMPLE = 3'b011,
      S_CONVERT = 3'b010,
      S_INTERVAL = 3'b110
   } sas_state_t;
endpackage : sas_pkg

// [logic/sas_sequencer.sv]
`timescale 1ns/1ps
module sas_sequencer (
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic TRIGGER,
   input wire logic HALT_STATE,
   input wire logic [sas_pkg::RW-1:0] CORE_RESULT,
   output logic [3:0] CORE_CHANNEL,
   output logic CORE_DISCHARGE,
   output logic CORE_SAMPLE,
   output logic CORE_CONVERT,
   output logic RUNNING,
   output logic IRQ
);
   // Returns {found, channel} of the lowest enabled channel at or above from
   function automatic logic [4:0] next_chan(input logic [sas_pkg::NCH-1:0] en,
                                            input logic [4:0] from);
      logic [4:0] r;
      r = 5'h00;
      for (int i = sas_pkg::NCH - 1; i >= 0; i--) begin
         if (en[i] && (5'(i) >= from)) begin
            r = {1'b1, 4'(i)};
         end
      end
      return r;
   endfunction : next_chan

   sas_pkg::sas_mode_t mode, next_mode;
   logic [4:0] ctrl, next_ctrl;
   logic [7:0] interval, next_interval;
   logic [1:0] imode, next_imode;
   logic [1:0] limmode, next_limmode;
   logic [sas_pkg::RW-1:0] upper, next_upper, lower, next_lower;
   logic [sas_pkg::NCH-1:0] chen, next_chen, lstat, next_lstat;
   logic [sas_pkg::RW-1:0] res [sas_pkg::NCH];
   logic [sas_pkg::RW-1:0] next_res [sas_pkg::NCH];
   logic [sas_pkg::RW-1:0] last, next_last;
   logic [sas_pkg::NEV-1:0] istat, next_istat, ien, next_ien;
   sas_pkg::sas_state_t state, next_state;
   logic [7:0] cnt, next_cnt;
   logic [3:0] chan, next_chan_r;
   logic run, next_run;
   logic [2:0] div;
   logic trig_s1, trig_s2, trig_d, halt_d;
   logic tick, wr, rd_ok, start, last_ch, match, conv_evt;
   logic [2:0] tmask;
   logic [4:0] nxt;
   logic [3:0] ridx;
   logic [sas_pkg::NEV-1:0] ev;

   assign wr = PSEL && PENABLE && PWRITE;
   assign PREADY = 1'b1;
   assign RUNNING = run;
   assign IRQ = |(istat & ien);
   assign CORE_CHANNEL = chan;
   assign CORE_DISCHARGE = (state == sas_pkg::S_INIT) && mode.discharge_enable;
   assign CORE_SAMPLE = (state == sas_pkg::S_SAMPLE);
   assign CORE_CONVERT = (state == sas_pkg::S_CONVERT);
   assign ridx = 4'((PADDR - sas_pkg::A_RES0) >> 2);

   always_comb begin
      case (mode.conv_clock_select)
         2'h0: tmask = 3'h0;
         2'h1: tmask = 3'h1;
         2'h2: tmask = 3'h3;
         default: tmask = 3'h7;
      endcase
      tick = ((div & tmask) == tmask);
   end

   // APB read side; unmapped reads return zero with an error answer
   always_comb begin
      PRDATA = 32'h0000_0000;
      rd_ok = 1'b1;
      if (PADDR >= sas_pkg::A_RES0 && PADDR <= sas_pkg::A_RES11 && PADDR[1:0] == 2'h0) begin
         PRDATA[sas_pkg::RES_LSB +: sas_pkg::RW] = res[ridx];
      end else begin
         case (PADDR)
            sas_pkg::A_MODE: PRDATA[15:0] = mode;
            sas_pkg::A_CTRL: PRDATA[5:0] = {run, 1'b0, ctrl[3:1], 1'b0};
            sas_pkg::A_INTERVAL: PRDATA[7:0] = interval;
            sas_pkg::A_IMODE: PRDATA[1:0] = imode;
            sas_pkg::A_LIMMODE: PRDATA[1:0] = limmode;
            sas_pkg::A_UPPER: PRDATA[11:0] = upper;
            sas_pkg::A_LOWER: PRDATA[11:0] = lower;
            sas_pkg::A_CHEN: PRDATA[11:0] = chen;
            sas_pkg::A_LSTAT: PRDATA[11:0] = lstat;
            sas_pkg::A_LCLR: PRDATA = 32'h0000_0000;
            sas_pkg::A_LAST: PRDATA[sas_pkg::RES_LSB +: sas_pkg::RW] = last;
            sas_pkg::A_ISTAT: PRDATA[2:0] = istat;
            sas_pkg::A_ICLR: PRDATA = 32'h0000_0000;
            sas_pkg::A_IEN: PRDATA[2:0] = ien;
            default: rd_ok = 1'b0;
         endcase
      end
      PSLVERR = PSEL && PENABLE && !rd_ok;
   end

   always_comb begin
      next_mode = mode;
      next_ctrl = ctrl;
      next_interval = interval;
      next_imode = imode;
      next_limmode = limmode;
      next_upper = upper;
      next_lower = lower;
      next_chen = chen;
      next_lstat = lstat;
      next_res = res;
      next_last = last;
      next_ien = ien;
      next_state = state;
      next_cnt = cnt;
      next_chan_r = chan;
      next_run = run;
      ev = '0;
      match = 1'b0;
      conv_evt = 1'b0;
      last_ch = 1'b0;
      nxt = 5'h00;
      if (wr) begin
         case (PADDR)
            sas_pkg::A_MODE: next_mode = PWDATA[15:0];
            sas_pkg::A_CTRL: next_ctrl[3:1] = PWDATA[3:1];
            sas_pkg::A_INTERVAL: next_interval = PWDATA[7:0];
            sas_pkg::A_IMODE: next_imode = PWDATA[1:0];
            sas_pkg::A_LIMMODE: next_limmode = PWDATA[1:0];
            sas_pkg::A_UPPER: next_upper = PWDATA[11:0];
            sas_pkg::A_LOWER: next_lower = PWDATA[11:0];
            sas_pkg::A_CHEN: next_chen = PWDATA[11:0];
            sas_pkg::A_LCLR: next_lstat = lstat & ~PWDATA[11:0];
            sas_pkg::A_IEN: next_ien = PWDATA[2:0];
            default: ;
         endcase
      end
      // Start and stop are accepted in any cycle, not only on ticks
      start = (wr && PADDR == sas_pkg::A_CTRL && PWDATA[sas_pkg::CTRL_START])
         || (ctrl[sas_pkg::CTRL_TRIG] && trig_s2 && !trig_d)
         || (ctrl[sas_pkg::CTRL_HALT] && HALT_STATE && !halt_d);
      if (state == sas_pkg::S_IDLE) begin
         nxt = next_chan(chen, 5'h00);
         if (start && nxt[4]) begin
            next_state = sas_pkg::S_INIT;
            next_chan_r = nxt[3:0];
            next_cnt = 8'h00;
            next_run = 1'b1;
         end
      end else if (wr && PADDR == sas_pkg::A_CTRL && PWDATA[sas_pkg::CTRL_STOP]) begin
         next_state = sas_pkg::S_IDLE;
         next_run = 1'b0;
         ev[sas_pkg::EV_DONE] = 1'b1;
      end else if (tick) begin
         next_cnt = cnt + 8'h01;
         unique case (state)
            sas_pkg::S_INIT: begin
               if (cnt >= {4'h0, mode.init_phase_time}) begin
                  next_state = sas_pkg::S_SAMPLE;
                  next_cnt = 8'h00;
               end
            end
            sas_pkg::S_SAMPLE: begin
               if (cnt >= {4'h0, mode.sample_hold_time}) begin
                  next_state = sas_pkg::S_CONVERT;
                  next_cnt = 8'h00;
               end
            end
            sas_pkg::S_CONVERT: begin
               if (cnt == 8'(sas_pkg::CONV_TICKS - 1)) begin
                  next_cnt = 8'h00;
                  next_res[chan] = CORE_RESULT;
                  next_last = CORE_RESULT;
                  match = (CORE_RESULT <= upper) && (CORE_RESULT >= lower);
                  if (limmode[0] && match) begin
                     next_lstat[chan] = 1'b1;
                     ev[sas_pkg::EV_LIMIT] = 1'b1;
                  end
                  nxt = next_chan(chen, {1'b0, chan} + 5'h01);
                  if (ctrl[sas_pkg::CTRL_CONT]) begin
                     last_ch = 1'b1;
                     if (mode.discharge_enable && interval != 8'h00) begin
                        next_state = sas_pkg::S_INTERVAL;
                     end else if (mode.discharge_enable) begin
                        next_state = sas_pkg::S_INIT;
                     end else begin
                        next_state = sas_pkg::S_SAMPLE;
                     end
                  end else if (nxt[4]) begin
                     next_state = sas_pkg::S_INIT;
                     next_chan_r = nxt[3:0];
                  end else begin
                     last_ch = 1'b1;
                     next_state = sas_pkg::S_IDLE;
                     next_run = 1'b0;
                     ev[sas_pkg::EV_DONE] = 1'b1;
                  end
                  // Limit-gated interrupt: with limmode bit 0 set, only matches report unless imode bit 1 set
                  conv_evt = (imode[0] || last_ch)
                     && (imode[1] || !limmode[0] || match);
                  ev[sas_pkg::EV_CONV] = conv_evt;
               end
            end
            sas_pkg::S_INTERVAL: begin
               if (cnt >= interval - 8'h01) begin
                  next_state = sas_pkg::S_INIT;
                  next_cnt = 8'h00;
               end
            end
            default: begin
               next_state = sas_pkg::S_IDLE;
               next_run = 1'b0;
            end
         endcase
      end
      // Hardware set wins over a same-cycle software clear
      next_istat = istat;
      if (wr && PADDR == sas_pkg::A_ICLR) begin
         next_istat = istat & ~PWDATA[2:0];
      end
      next_istat = next_istat | ev;
   end

   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         mode <= sas_pkg::MODE_RESET;
         ctrl <= 5'h00;
         interval <= 8'h00;
         imode <= 2'h0;
         limmode <= 2'h0;
         upper <= sas_pkg::UPPER_RESET;
         lower <= 12'h000;
         chen <= 12'h000;
         lstat <= 12'h000;
         for (int i = 0; i < sas_pkg::NCH; i++) begin
            res[i] <= 12'h000;
         end
         last <= 12'h000;
         istat <= 3'h0;
         ien <= 3'h0;
         state <= sas_pkg::S_IDLE;
         cnt <= 8'h00;
         chan <= 4'h0;
         run <= 1'b0;
         div <= 3'h0;
         trig_s1 <= 1'b0;
         trig_s2 <= 1'b0;
         trig_d <= 1'b0;
         halt_d <= 1'b0;
      end else begin
         mode <= next_mode;
         ctrl <= next_ctrl;
         interval <= next_interval;
         imode <= next_imode;
         limmode <= next_limmode;
         upper <= next_upper;
         lower <= next_lower;
         chen <= next_chen;
         lstat <= next_lstat;
         res <= next_res;
         last <= next_last;
         istat <= next_istat;
         ien <= next_ien;
         state <= next_state;
         cnt <= next_cnt;
         chan <= next_chan_r;
         run <= next_run;
         div <= div + 3'h1;
         trig_s1 <= TRIGGER;
         trig_s2 <= trig_s1;
         trig_d <= trig_s2;
         halt_d <= HALT_STATE;
      end
   end
endmodule : sas_sequencer

// [test/sas_core_model.sv]
`timescale 1ns/1ps
module sas_core_model (
   input wire logic clk,
   input wire logic [3:0] channel,
   input wire logic convert,
   input wire logic [11:0] base,
   output logic [11:0] result
);
   // Drifts while idle, so a stale sample never passes for a result
   always @(posedge clk) result <= convert ? base + {8'h00, channel} : ~result;
endmodule : sas_core_model

// [test/sas_props.sv]
`timescale 1ns/1ps
module sas_props (
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic TRIGGER,
   input wire logic HALT_STATE,
   input wire logic [sas_pkg::RW-1:0] CORE_RESULT,
   input wire logic [3:0] CORE_CHANNEL,
   input wire logic CORE_DISCHARGE,
   input wire logic CORE_SAMPLE,
   input wire logic CORE_CONVERT,
   input wire logic RUNNING,
   input wire logic IRQ
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RSTN);
   logic [7:0] conv_cnt;
   logic [7:0] next_conv_cnt;
   always_comb next_conv_cnt = CORE_CONVERT ? conv_cnt + 8'h01 : 8'h00;
   always_ff @(posedge CLK) conv_cnt <= RSTN ? next_conv_cnt : 8'h00;
   sequence s_access;
      PSEL && PENABLE;
   endsequence
   sequence s_stop;
      s_access ##0 PWRITE && PADDR == sas_pkg::A_CTRL && PWDATA[sas_pkg::CTRL_STOP]
         && !PWDATA[sas_pkg::CTRL_START];
   endsequence
   a_unmapped_refused: assert property (
      s_access ##0 PADDR == 8'h80 |-> PSLVERR && PRDATA == 32'h0) else $error("unmapped ok");
   a_clear_reads_zero: assert property (
      s_access ##0 !PWRITE && PADDR == sas_pkg::A_LCLR |-> PRDATA == 32'h0) else $error("lclr read");
   a_stop_idles: assert property (
      s_stop |=> !RUNNING) else $error("stop ignored");
   a_one_phase: assert property (
      $onehot0({CORE_DISCHARGE, CORE_SAMPLE, CORE_CONVERT})) else $error("phases overlap");
   a_phase_in_run: assert property (
      CORE_DISCHARGE || CORE_SAMPLE || CORE_CONVERT |-> RUNNING) else $error("phase outside run");
   a_sample_first: assert property (
      $rose(CORE_CONVERT) |-> $past(CORE_SAMPLE)) else $error("convert without sampling");
   a_convert_full: assert property (
      $fell(CORE_CONVERT) && RUNNING |-> conv_cnt >= 8'h0C) else $error("conversion cut short");
   a_channel_up: assert property (
      RUNNING && $past(RUNNING) && $changed(CORE_CHANNEL) |-> CORE_CHANNEL > $past(CORE_CHANNEL))
      else $error("channel order broken");
   a_discharge_sample: assert property (
      $fell(CORE_DISCHARGE) && RUNNING |-> CORE_SAMPLE) else $error("no sample after discharge");
endmodule : sas_props
bind sas_sequencer sas_props u_props (.CLK, .RSTN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
   .PRDATA, .PREADY, .PSLVERR, .TRIGGER, .HALT_STATE, .CORE_RESULT, .CORE_CHANNEL,
   .CORE_DISCHARGE, .CORE_SAMPLE, .CORE_CONVERT, .RUNNING, .IRQ);

// [test/sar_adc_conversion_sequencer_bench.sv]
`timescale 1ns/1ps
module sar_adc_conversion_sequencer_bench;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic trig = 1'b0;
   logic halt = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [11:0] base = 12'h000;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic [11:0] res;
   logic [3:0] ch;
   logic pready, pslverr, running, irq, dis, smp, cnv, err;
   integer fail_count = 0;
   integer checked = 0;
   integer seed = 96;
   integer exp_res [12];
   integer exp_ls = 0;
   integer exp_is = 0;
   integer n_dis, n_smp, n_cnv, n_run, i;
   sas_sequencer u_dut (.CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .TRIGGER(trig), .HALT_STATE(halt), .CORE_RESULT(res), .CORE_CHANNEL(ch),
      .CORE_DISCHARGE(dis), .CORE_SAMPLE(smp), .CORE_CONVERT(cnv), .RUNNING(running), .IRQ(irq));
   sas_core_model u_core (.clk(clk), .channel(ch), .convert(cnv), .base(base), .result(res));
   initial forever #2.5 clk = ~clk;
   task report_and_stop;
      $display("Checks %0d, mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : report_and_stop
   task cmp(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      integer k;
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      if (k >= 50) begin
         fail_count++;
         report_and_stop;
      end
   endtask : apb
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task rd_cmp(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      cmp(rd, e);
   endtask : rd_cmp
   task meas;
      integer k;
      n_dis = 0;
      n_smp = 0;
      n_cnv = 0;
      n_run = 0;
      k = 0;
      while (running !== 1'b1 && k < 20) begin
         @(posedge clk);
         k++;
      end
      while (running === 1'b1 && k < 5000) begin
         n_dis += dis;
         n_smp += smp;
         n_cnv += cnv;
         n_run += 1;
         @(posedge clk);
         k++;
      end
      if (running !== 1'b0 || n_cnv == 0) begin
         fail_count++;
         report_and_stop;
      end
   endtask : meas
   task model(input logic [11:0] chen, input integer im, input integer ce, input integer lo,
              input integer hi);
      integer r, last, m;
      last = -1;
      for (i = 0; i < 12; i++) if (chen[i]) last = i;
      for (i = 0; i < 12; i++) begin
         if (chen[i]) begin
            r = (base + i) & 12'hFFF;
            exp_res[i] = r;
            m = lo <= r && r <= hi;
            if (ce && m) begin
               exp_ls |= 1 << i;
               exp_is |= 4;
            end
            if ((im[0] || i == last) && (im[1] || !ce || m)) exp_is |= 1;
         end
      end
      exp_is |= 2;
   endtask : model
   task check_regs(input logic [11:0] chen);
      for (i = 0; i < 12; i++) begin
         if (chen[i]) rd_cmp(sas_pkg::A_RES0 + 8'(4 * i), exp_res[i] << sas_pkg::RES_LSB);
      end
      rd_cmp(sas_pkg::A_LSTAT, exp_ls);
      rd_cmp(sas_pkg::A_ISTAT, exp_is);
   endtask : check_regs
   initial begin
      integer im;
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      rd_cmp(sas_pkg::A_UPPER, 32'hFFF);
      rd_cmp(8'h80, 32'h0);
      cmp(err, 32'h1);
      wr(sas_pkg::A_MODE, 32'h3120);
      rd_cmp(sas_pkg::A_MODE, 32'h3120);
      wr(sas_pkg::A_CHEN, 32'h3);
      wr(sas_pkg::A_IMODE, 32'h1);
      wr(sas_pkg::A_LIMMODE, 32'h1);
      wr(sas_pkg::A_IEN, 32'h1);
      base <= 12'($random(seed));
      wr(sas_pkg::A_CTRL, 32'h1);
      meas;
      cmp(running, 32'h0);
      model(12'h003, 1, 1, 0, 4095);
      cmp(n_dis, 32'h6);
      cmp(n_smp, 32'h8);
      cmp(n_cnv, 32'h18);
      check_regs(12'h003);
      cmp(irq, 32'h1);
      wr(sas_pkg::A_LCLR, 32'h1);
      exp_ls = 2;
      rd_cmp(sas_pkg::A_LSTAT, exp_ls);
      wr(sas_pkg::A_LCLR, 32'h0);
      rd_cmp(sas_pkg::A_LSTAT, exp_ls);
      rd_cmp(sas_pkg::A_LCLR, 32'h0);
      wr(sas_pkg::A_ICLR, 32'h7);
      exp_is = 0;
      @(posedge clk);
      cmp(irq, 32'h0);
      wr(sas_pkg::A_MODE, 32'h1002);
      wr(sas_pkg::A_CHEN, 32'h801);
      wr(sas_pkg::A_IMODE, 32'h0);
      wr(sas_pkg::A_LOWER, 32'hFFF);
      wr(sas_pkg::A_UPPER, 32'h0);
      base <= 12'($random(seed));
      wr(sas_pkg::A_CTRL, 32'h1);
      meas;
      model(12'h801, 0, 1, 4095, 0);
      cmp(n_smp, 32'h10);
      cmp(n_cnv, 32'h60);
      check_regs(12'h801);
      cmp(irq, 32'h0);
      // Stabilisation of four ticks, no discharge, so it shows only as idle run time
      wr(sas_pkg::A_MODE, 32'h0030);
      wr(sas_pkg::A_CHEN, 32'h2);
      for (im = 2; im < 4; im++) begin
         wr(sas_pkg::A_ICLR, 32'h7);
         exp_is = 0;
         wr(sas_pkg::A_IMODE, im);
         wr(sas_pkg::A_CTRL, 32'h4);
         base <= 12'($random(seed));
         trig <= 1'b1;
         meas;
         cmp(n_run - n_smp - n_cnv, 32'h4);
         trig <= 1'b0;
         model(12'h002, im, 1, 4095, 0);
         check_regs(12'h002);
      end
      wr(sas_pkg::A_CTRL, 32'h8);
      halt <= 1'b1;
      meas;
      halt <= 1'b0;
      model(12'h002, 3, 1, 4095, 0);
      check_regs(12'h002);
      wr(sas_pkg::A_MODE, 32'h0100);
      wr(sas_pkg::A_INTERVAL, 32'h5);
      wr(sas_pkg::A_CTRL, 32'h3);
      repeat (40) @(posedge clk);
      n_dis = 0;
      // Window is ten whole periods, so the count does not depend on phase
      repeat (190) begin
         @(posedge clk);
         n_dis += dis;
      end
      cmp(n_dis, 32'hA);
      cmp(running, 32'h1);
      wr(sas_pkg::A_CTRL, 32'h10);
      @(posedge clk);
      cmp(running, 32'h0);
      // Continuous without discharge: no interval allowed, sample then convert back to back
      wr(sas_pkg::A_INTERVAL, 32'h0);
      wr(sas_pkg::A_MODE, 32'h0);
      wr(sas_pkg::A_CTRL, 32'h3);
      repeat (40) @(posedge clk);
      n_smp = 0;
      repeat (130) begin
         @(posedge clk);
         n_smp += smp;
      end
      cmp(n_smp, 32'hA);
      cmp(running, 32'h1);
      wr(sas_pkg::A_CTRL, 32'h10);
      @(posedge clk);
      cmp(running, 32'h0);
      report_and_stop;
   end
endmodule : sar_adc_conversion_sequencer_bench
